// ### rtl/gtm_pkg.sv
// Register map, fields and reset values of the timer
package gtm_pkg;

    // Register byte offsets
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_GLOBAL_CFG = 12'h000;
    localparam logic [11:0] OFF_MODE_A = 12'h004;
    localparam logic [11:0] OFF_MODE_B = 12'h008;
    localparam logic [11:0] OFF_CONTROL = 12'h00C;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h018;
    localparam logic [11:0] OFF_RAW_STATUS = 12'h01C;
    localparam logic [11:0] OFF_MASKED_STATUS = 12'h020;
    localparam logic [11:0] OFF_IRQ_CLEAR = 12'h024;
    localparam logic [11:0] OFF_LOAD_A = 12'h028;
    localparam logic [11:0] OFF_LOAD_B = 12'h02C;
    localparam logic [11:0] OFF_MATCH_A = 12'h030;
    localparam logic [11:0] OFF_MATCH_B = 12'h034;
    localparam logic [11:0] OFF_PRESCALE_A = 12'h038;
    localparam logic [11:0] OFF_PRESCALE_B = 12'h03C;
    localparam logic [11:0] OFF_PRE_MATCH_A = 12'h040;
    localparam logic [11:0] OFF_PRE_MATCH_B = 12'h044;
    localparam logic [11:0] OFF_VALUE_A = 12'h048;
    localparam logic [11:0] OFF_VALUE_B = 12'h04C;
    localparam logic [11:0] OFF_HALF_STEP = 12'h004;

    // Configuration encodings
    localparam logic [2:0] CFG_WIDE = 3'h0;
    localparam logic [2:0] CFG_RTC = 3'h1;
    localparam int CFG_SPLIT_BIT = 2;

    // Mode register fields
    localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
    localparam logic [1:0] MODE_PERIODIC = 2'h2;
    localparam logic [1:0] MODE_CAPTURE = 2'h3;
    localparam int MR_KIND_BIT = 2;
    localparam int MR_ALT_BIT = 3;

    // Control fields; half B is CTL_HALF_STEP bits up
    localparam int CTL_HALF_STEP = 8;
    localparam int CTL_EN = 0;
    localparam int CTL_STALL = 1;
    localparam int CTL_EVT_LO = 2;
    localparam int CTL_RTC_EN = 4;
    localparam int CTL_INV = 6;
    localparam logic [15:0] CTL_WMASK = 16'h4F5F;
    localparam logic [1:0] EVT_RISE = 2'h0;
    localparam logic [1:0] EVT_FALL = 2'h1;
    localparam logic [1:0] EVT_BOTH = 2'h3;

    // Status bits; half B is IRQ_HALF_STEP bits up
    localparam int IRQ_HALF_STEP = 8;
    localparam int IRQ_TIMEOUT = 0;
    localparam int IRQ_CMATCH = 1;
    localparam int IRQ_CEVENT = 2;
    localparam int IRQ_RTC = 3;
    localparam logic [15:0] IRQ_WMASK = 16'h070F;

    // Reset values and the 16-bit half mask
    localparam logic [31:0] LOAD_RST_WIDE = 32'hFFFF_FFFF;
    localparam logic [31:0] LOAD_RST_HALF = 32'h0000_FFFF;
    localparam logic [31:0] HALF_MASK = 32'h0000_FFFF;
    localparam logic [7:0] PRE_RST = 8'h00;

endpackage

// ### rtl/gtm_timer.sv
// General-purpose timer: 32-bit, real-time clock and split 16-bit modes
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/10ps

// Functional notes
// R01: Peripheral clock is gated on before use.
// R02: Run-enable is cleared before any setting changes.
// R03: Config 0x0: one 32-bit timer, half A mode field picks behaviour.
// R04: Config 0x1: 32-bit real-time-clock counter.
// R05: Config 0x4: two independent 16-bit timers.
// R06: Mode 0x1 is one-shot, 0x2 periodic.
// R07: One-shot stops at time-out; periodic runs on.
// R08: Setting run-enable starts counting from the load value.
// R09: Time-out sets raw flag; interrupt only if masked in.
// R10: Writing 1 to a clear bit drops raw and masked flags.
// R11: Far side drives a 32.768 kHz reference on a capture pin.
// R12: Real-time clock reloads zero on match, counts on upward.
// R13: Clock match has its own mask and clears itself.
// R14: Prescale stretches the period in 16-bit one-shot and periodic.
// R15: Capture kind 0 with mode 0x3 gives input edge count.
// R16: Capture kind 1 with mode 0x3 gives input edge timing.
// R17: Event-type field picks rising, falling or both edges.
// R18: Edge count stops at match, sets count-match flag.
// R19: Edge timing captures the counter, sets capture-event flag.
// R20: Edge timing runs on; a load write acts next cycle.
// R21: Alternate bit 1, kind 0 and mode 0x2 give PWM.
// R22: PWM runs free; load writes act next cycle; prescaler uses both registers.
// R23: Halves count down 16 bits, plus an 8-bit prescaler.
// R24: One-shot at zero reloads, stops and clears its run-enable.
// R25: PWM rises at load, falls at match, may be inverted.
// R26: Halves run apart, sharing control and interrupt registers.
module gtm_timer (
    input wire logic ref_clk_i, // 10 MHz clock
    input wire logic rst_b_i, // Async reset, active low
    input wire logic [gtm_pkg::ADDR_W-1:0] addr_i, // Register byte address
    input wire logic [31:0] wr_data_i, // Write data
    input wire logic wr_en_i, // Write strobe
    input wire logic rd_en_i, // Read strobe
    input wire logic ccp_a_i, // Capture pin A, also clock reference
    input wire logic ccp_b_i, // Capture pin B
    input wire logic freeze_i, // Debug freeze request
    output logic [31:0] rd_data_o, // Read data, cycle after strobe
    output logic pwm_a_o, // Waveform out, half A
    output logic pwm_b_o, // Waveform out, half B
    output logic irq_o // Masked interrupt
);

    // Software-visible registers
    logic [2:0] cfg_q;
    logic [3:0] mode_q [2];
    logic [15:0] ctl_q;
    logic [15:0] imr_q;
    logic [15:0] ris_q;
    logic [15:0] ris_d;
    logic [31:0] ilr_q [2];
    logic [31:0] match_q [2];
    logic [7:0] pr_q [2];
    logic [7:0] pmr_q [2];
    logic [31:0] rd_q;
    logic irq_q;

    // Per-half results
    logic [31:0] val_w [2];
    logic [3:0] ev_w [2];
    logic [1:0] stop_w;
    logic [1:0] start_w;
    logic [1:0] pwm_w;
    logic rtc_adv_w;

    // Write decodes
    logic wr_cfg;
    logic wr_ctl;
    logic wr_imr;
    logic wr_icr;
    logic [1:0] wr_mode;
    logic [1:0] wr_load;
    logic [1:0] wr_match;
    logic [1:0] wr_pr;
    logic [1:0] wr_pmr;
    logic [15:0] ris_set;
    logic [15:0] ris_clr;
    logic [31:0] rd_mux;

    assign wr_cfg = wr_en_i && addr_i == gtm_pkg::OFF_GLOBAL_CFG;
    assign wr_ctl = wr_en_i && addr_i == gtm_pkg::OFF_CONTROL;
    assign wr_imr = wr_en_i && addr_i == gtm_pkg::OFF_IRQ_MASK;
    assign wr_icr = wr_en_i && addr_i == gtm_pkg::OFF_IRQ_CLEAR;

    // Events, laid out as the status register
    assign ris_set = {4'h0, ev_w[1], 4'h0, ev_w[0]};
    // Clock match flag self-clears at next reference edge
    assign ris_clr = (wr_icr ? wr_data_i[15:0] : 16'h0) // R10
        | {12'h0, rtc_adv_w, 3'h0}; // R13
    // Set wins over clear so no event is lost
    assign ris_d = ((ris_q & ~ris_clr) | ris_set) & gtm_pkg::IRQ_WMASK; // R09

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_dec
            localparam logic [11:0] HO = 12'(i) * gtm_pkg::OFF_HALF_STEP;
            assign wr_mode[i] = wr_en_i && addr_i == gtm_pkg::OFF_MODE_A + HO;
            assign wr_load[i] = wr_en_i && addr_i == gtm_pkg::OFF_LOAD_A + HO;
            assign wr_match[i] = wr_en_i && addr_i == gtm_pkg::OFF_MATCH_A + HO;
            assign wr_pr[i] = wr_en_i && addr_i == gtm_pkg::OFF_PRESCALE_A + HO;
            assign wr_pmr[i] = wr_en_i && addr_i == gtm_pkg::OFF_PRE_MATCH_A + HO;
            // Software setting a run-enable bit
            assign start_w[i] = wr_ctl && wr_data_i[i * gtm_pkg::CTL_HALF_STEP + gtm_pkg::CTL_EN]
                && !ctl_q[i * gtm_pkg::CTL_HALF_STEP + gtm_pkg::CTL_EN]; // R08
        end
    endgenerate

    // Read selection; unmapped addresses read as zero
    always_comb begin
        case (addr_i)
            gtm_pkg::OFF_GLOBAL_CFG: rd_mux = {29'h0, cfg_q};
            gtm_pkg::OFF_MODE_A: rd_mux = {28'h0, mode_q[0]};
            gtm_pkg::OFF_MODE_B: rd_mux = {28'h0, mode_q[1]};
            gtm_pkg::OFF_CONTROL: rd_mux = {16'h0, ctl_q};
            gtm_pkg::OFF_IRQ_MASK: rd_mux = {16'h0, imr_q};
            gtm_pkg::OFF_RAW_STATUS: rd_mux = {16'h0, ris_q};
            gtm_pkg::OFF_MASKED_STATUS: rd_mux = {16'h0, ris_q & imr_q};
            gtm_pkg::OFF_LOAD_A: rd_mux = ilr_q[0];
            gtm_pkg::OFF_LOAD_B: rd_mux = ilr_q[1];
            gtm_pkg::OFF_MATCH_A: rd_mux = match_q[0];
            gtm_pkg::OFF_MATCH_B: rd_mux = match_q[1];
            gtm_pkg::OFF_PRESCALE_A: rd_mux = {24'h0, pr_q[0]};
            gtm_pkg::OFF_PRESCALE_B: rd_mux = {24'h0, pr_q[1]};
            gtm_pkg::OFF_PRE_MATCH_A: rd_mux = {24'h0, pmr_q[0]};
            gtm_pkg::OFF_PRE_MATCH_B: rd_mux = {24'h0, pmr_q[1]};
            gtm_pkg::OFF_VALUE_A: rd_mux = val_w[0]; // R19
            gtm_pkg::OFF_VALUE_B: rd_mux = val_w[1]; // R19
            default: rd_mux = 32'h0;
        endcase
    end

    // Shared config, control and interrupt registers
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_q <= gtm_pkg::CFG_WIDE;
            ctl_q <= 16'h0;
            imr_q <= 16'h0;
            ris_q <= 16'h0;
            irq_q <= 1'b0;
            rd_q <= 32'h0;
        end else begin
            if (wr_cfg) begin
                cfg_q <= wr_data_i[2:0]; // R03 R04 R05
            end
            if (wr_ctl) begin
                ctl_q <= wr_data_i[15:0] & gtm_pkg::CTL_WMASK;
            end else begin
                // Hardware drops run-enable after one-shot and edge count
                ctl_q[gtm_pkg::CTL_EN] <= ctl_q[gtm_pkg::CTL_EN] & ~stop_w[0]; // R24
                ctl_q[gtm_pkg::CTL_HALF_STEP + gtm_pkg::CTL_EN] <=
                    ctl_q[gtm_pkg::CTL_HALF_STEP + gtm_pkg::CTL_EN] & ~stop_w[1]; // R18
            end
            if (wr_imr) begin
                imr_q <= wr_data_i[15:0] & gtm_pkg::IRQ_WMASK; // R13
            end
            ris_q <= ris_d;
            irq_q <= |(ris_d & imr_q); // R09
            rd_q <= rd_en_i ? rd_mux : 32'h0;
        end
    end

    // Per-half load, match and prescale registers
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int k = 0; k < 2; k++) begin
                mode_q[k] <= 4'h0;
                ilr_q[k] <= (k == 0) ? gtm_pkg::LOAD_RST_WIDE : gtm_pkg::LOAD_RST_HALF;
                match_q[k] <= (k == 0) ? gtm_pkg::LOAD_RST_WIDE : gtm_pkg::LOAD_RST_HALF;
                pr_q[k] <= gtm_pkg::PRE_RST;
                pmr_q[k] <= gtm_pkg::PRE_RST;
            end
        end else begin
            for (int k = 0; k < 2; k++) begin
                // Half B is only ever 16 bits wide
                if (wr_mode[k]) begin
                    mode_q[k] <= wr_data_i[3:0];
                end
                if (wr_load[k]) begin
                    ilr_q[k] <= (k == 0) ? wr_data_i : (wr_data_i & gtm_pkg::HALF_MASK);
                end
                if (wr_match[k]) begin
                    match_q[k] <= (k == 0) ? wr_data_i : (wr_data_i & gtm_pkg::HALF_MASK);
                end
                if (wr_pr[k]) begin
                    pr_q[k] <= wr_data_i[7:0];
                end
                if (wr_pmr[k]) begin
                    pmr_q[k] <= wr_data_i[7:0];
                end
            end
        end
    end

    // Counting logic, one copy per half
    generate
        for (i = 0; i < 2; i++) begin : g_half
            localparam int CB = i * gtm_pkg::CTL_HALF_STEP;
            logic [31:0] cnt_q;
            logic [31:0] cnt_d;
            logic [7:0] pre_q;
            logic [7:0] pre_d;
            logic [15:0] capt_q;
            logic [15:0] capt_d;
            logic [2:0] ccp_s_q;
            logic pwm_lvl_q;
            logic pwm_lvl_d;
            logic pwm_q;
            logic to_ev;
            logic cm_ev;
            logic ce_ev;
            logic rtc_ev;
            logic stop;
            logic ccp_pin;
            logic wide;
            logic rtc;
            logic split;
            logic [1:0] md;
            logic pwm_m;
            logic shot_m;
            logic ecnt_m;
            logic etim_m;
            logic en;
            logic run;
            logic rise;
            logic fall;
            logic edge_ev;
            logic [1:0] evt;
            logic use_pre;
            logic [31:0] cmask;
            logic [31:0] cnt_lo;
            logic [31:0] cnt_dec;
            logic [31:0] load_val;
            logic [31:0] match_val;

            // Mode decode
            assign ccp_pin = (i == 0) ? ccp_a_i : ccp_b_i;
            assign wide = (i == 0) && cfg_q == gtm_pkg::CFG_WIDE; // R03
            assign rtc = (i == 0) && cfg_q == gtm_pkg::CFG_RTC; // R04
            assign split = cfg_q[gtm_pkg::CFG_SPLIT_BIT]; // R05 R26
            assign md = mode_q[i][1:0];
            assign pwm_m = split && mode_q[i][gtm_pkg::MR_ALT_BIT] && !mode_q[i][gtm_pkg::MR_KIND_BIT]
                && md == gtm_pkg::MODE_PERIODIC; // R21
            assign shot_m = (wide || split) && !pwm_m
                && (md == gtm_pkg::MODE_ONE_SHOT || md == gtm_pkg::MODE_PERIODIC); // R06
            assign ecnt_m = split && md == gtm_pkg::MODE_CAPTURE && !mode_q[i][gtm_pkg::MR_KIND_BIT]; // R15
            assign etim_m = split && md == gtm_pkg::MODE_CAPTURE && mode_q[i][gtm_pkg::MR_KIND_BIT]; // R16

            // Clock counter ignores freeze while its CTL_RTC_EN bit is set
            assign en = ctl_q[CB + gtm_pkg::CTL_EN];
            assign run = en && !(freeze_i && ctl_q[CB + gtm_pkg::CTL_STALL]
                && !(rtc && ctl_q[gtm_pkg::CTL_RTC_EN]));

            // Edge selection on the synchronised pin
            assign rise = ccp_s_q[1] && !ccp_s_q[2];
            assign fall = !ccp_s_q[1] && ccp_s_q[2];
            assign evt = ctl_q[CB + gtm_pkg::CTL_EVT_LO +: 2];
            assign edge_ev = (evt == gtm_pkg::EVT_RISE) ? rise : (evt == gtm_pkg::EVT_FALL) ? fall
                : (evt == gtm_pkg::EVT_BOTH) ? (rise || fall) : 1'b0; // R17

            // Counter width: 32 bits whole, 16 bits split
            assign cmask = (wide || rtc) ? gtm_pkg::LOAD_RST_WIDE : gtm_pkg::HALF_MASK; // R23
            assign cnt_lo = cnt_q & cmask;
            assign cnt_dec = (cnt_lo - 32'h1) & cmask;
            assign load_val = ilr_q[i] & cmask;
            assign match_val = match_q[i] & cmask;
            // Prescaler only in split timer and waveform modes
            assign use_pre = split && (shot_m || pwm_m); // R14

            // Next count
            always_comb begin
                cnt_d = cnt_q;
                pre_d = pre_q;
                capt_d = capt_q;
                to_ev = 1'b0;
                cm_ev = 1'b0;
                ce_ev = 1'b0;
                rtc_ev = 1'b0;
                stop = 1'b0;
                if (start_w[i]) begin
                    cnt_d = rtc ? 32'h0 : load_val; // R08
                    pre_d = pr_q[i];
                end else if (wr_load[i] && en && !rtc && !ecnt_m) begin
                    // New interval takes over on the next cycle
                    cnt_d = wr_data_i & cmask; // R20 R22
                    pre_d = pr_q[i];
                end else if (rtc) begin
                    if (run && rise) begin
                        if (cnt_q == match_q[i]) begin
                            cnt_d = 32'h0; // R12
                            rtc_ev = 1'b1; // R13
                        end else begin
                            cnt_d = cnt_q + 32'h1; // R12
                        end
                    end
                end else if (ecnt_m) begin
                    if (run && edge_ev) begin
                        if (cnt_dec == match_val) begin
                            cm_ev = 1'b1; // R18
                            cnt_d = load_val;
                            stop = 1'b1; // R18
                        end else begin
                            cnt_d = cnt_dec;
                        end
                    end
                end else if (etim_m) begin
                    if (run) begin
                        if (edge_ev) begin
                            capt_d = cnt_lo[15:0]; // R19
                            ce_ev = 1'b1; // R19
                        end
                        cnt_d = (cnt_lo == 32'h0) ? load_val : cnt_dec; // R20
                    end
                end else if (shot_m || pwm_m) begin
                    if (run) begin
                        if (use_pre && pre_q != 8'h00) begin
                            pre_d = pre_q - 8'h01; // R14
                        end else if (cnt_lo == 32'h0) begin
                            cnt_d = load_val; // R24
                            pre_d = pr_q[i];
                            to_ev = !pwm_m; // R09
                            stop = shot_m && md == gtm_pkg::MODE_ONE_SHOT; // R07 R24
                        end else begin
                            cnt_d = cnt_dec; // R07 R23
                            pre_d = pr_q[i];
                        end
                    end
                end
            end

            // Waveform level, prescaler compared too
            assign pwm_lvl_d = !(pwm_m && en) ? 1'b0
                : (cnt_lo == load_val && pre_q == pr_q[i]) ? 1'b1 // R25
                : (cnt_lo == match_val && pre_q == pmr_q[i]) ? 1'b0 // R22 R25
                : pwm_lvl_q;

            // Half state
            always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    cnt_q <= (i == 0) ? gtm_pkg::LOAD_RST_WIDE : gtm_pkg::LOAD_RST_HALF;
                    pre_q <= gtm_pkg::PRE_RST;
                    capt_q <= 16'h0;
                    ccp_s_q <= 3'h0;
                    pwm_lvl_q <= 1'b0;
                    pwm_q <= 1'b0;
                end else begin
                    cnt_q <= cnt_d;
                    pre_q <= pre_d;
                    capt_q <= capt_d;
                    // Pin crosses two flops before edge detection
                    ccp_s_q <= {ccp_s_q[1:0], ccp_pin};
                    pwm_lvl_q <= pwm_lvl_d;
                    pwm_q <= pwm_m && (pwm_lvl_d ^ ctl_q[CB + gtm_pkg::CTL_INV]); // R25
                end
            end

            assign val_w[i] = etim_m ? {16'h0, capt_q} : cnt_lo; // R19
            assign ev_w[i] = {rtc_ev, ce_ev, cm_ev, to_ev}; // R09 R18 R19
            assign stop_w[i] = stop;
            assign pwm_w[i] = pwm_q;
        end
    endgenerate

    // Clock match flag drops at the next reference step
    assign rtc_adv_w = g_half[0].rtc && g_half[0].run && g_half[0].rise && !g_half[0].rtc_ev; // R13

    assign rd_data_o = rd_q;
    assign pwm_a_o = pwm_w[0];
    assign pwm_b_o = pwm_w[1];
    assign irq_o = irq_q;

endmodule

// ### test/gtm_ccp_src.sv
// Edge source for the capture/compare pins
`timescale 1ns/10ps
module gtm_ccp_src (
    output logic ccp_a_o, // Capture pin A drive
    output logic ccp_b_o // Capture pin B drive
);
    logic [1:0] pin_q = 2'b00;
    // Idle low, as with a pull-down
    assign ccp_a_o = pin_q[0];
    assign ccp_b_o = pin_q[1];
    // Whole pulses: one rise, one fall each
    task pulse(input bit on_b, int n, half_ns);
        for (int i = 0; i < n; i++) begin
            pin_q[on_b] = 1'b1;
            #(half_ns);
            pin_q[on_b] = 1'b0;
            #(half_ns);
        end
    endtask
endmodule

// ### test/gtm_timer_props.sv
// Port-level assertions for the timer
`timescale 1ns/10ps
module gtm_timer_props (
    input logic ref_clk_i, // Clock
    input logic rst_b_i, // Reset, active low
    input logic [gtm_pkg::ADDR_W-1:0] addr_i, // Address
    input logic [31:0] wr_data_i, // Write data
    input logic wr_en_i, // Write strobe
    input logic rd_en_i, // Read strobe
    input logic [31:0] rd_data_o, // Read data
    input logic pwm_a_o, // Waveform A
    input logic pwm_b_o, // Waveform B
    input logic irq_o // Interrupt
);
    logic [15:0] mask_q;
    logic [3:0] mode_a_q;
    logic [3:0] mode_b_q;
    // Shadow settings; outputs lag a cycle
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mask_q <= 16'h0000;
            mode_a_q <= 4'h0;
            mode_b_q <= 4'h0;
        end else if (wr_en_i) begin
            if (addr_i == gtm_pkg::OFF_IRQ_MASK) mask_q <= wr_data_i[15:0] & gtm_pkg::IRQ_WMASK;
            if (addr_i == gtm_pkg::OFF_MODE_A) mode_a_q <= wr_data_i[3:0];
            if (addr_i == gtm_pkg::OFF_MODE_B) mode_b_q <= wr_data_i[3:0];
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_cfg_back;
        (wr_en_i && addr_i == gtm_pkg::OFF_GLOBAL_CFG) ##1 (rd_en_i && addr_i == gtm_pkg::OFF_GLOBAL_CFG)
            |=> rd_data_o == ($past(wr_data_i, 2) & 32'h7);
    endproperty
    a_cfg_back: assert property (p_cfg_back) else $error("config readback wrong");
    property p_mode_back;
        (wr_en_i && addr_i == gtm_pkg::OFF_MODE_A) ##1 (rd_en_i && addr_i == gtm_pkg::OFF_MODE_A)
            |=> rd_data_o == ($past(wr_data_i, 2) & 32'hF);
    endproperty
    a_mode_back: assert property (p_mode_back) else $error("mode readback wrong");
    property p_imr_back;
        (wr_en_i && addr_i == gtm_pkg::OFF_IRQ_MASK) ##1 (rd_en_i && addr_i == gtm_pkg::OFF_IRQ_MASK)
            |=> rd_data_o == ($past(wr_data_i, 2) & {16'h0, gtm_pkg::IRQ_WMASK});
    endproperty
    a_imr_back: assert property (p_imr_back) else $error("mask readback wrong");
    property p_mis_subset;
        rd_en_i && addr_i == gtm_pkg::OFF_MASKED_STATUS |=> (rd_data_o & ~{16'h0, $past(mask_q)}) == 32'h0;
    endproperty
    a_mis_subset: assert property (p_mis_subset) else $error("masked status outside mask");
    property p_irq_mask;
        irq_o |-> (mask_q | $past(mask_q)) != 16'h0;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("interrupt with all masked");
    property p_clear;
        wr_en_i && addr_i == gtm_pkg::OFF_IRQ_CLEAR && wr_data_i == 32'hFFFF_FFFF |-> ##2 !irq_o;
    endproperty
    a_clear: assert property (p_clear) else $error("interrupt survives clear");
    property p_pwm_a;
        pwm_a_o |-> mode_a_q == 4'hA || $past(mode_a_q) == 4'hA;
    endproperty
    a_pwm_a: assert property (p_pwm_a) else $error("waveform A outside its mode");
    property p_pwm_b;
        pwm_b_o |-> mode_b_q == 4'hA || $past(mode_b_q) == 4'hA;
    endproperty
    a_pwm_b: assert property (p_pwm_b) else $error("waveform B outside its mode");
endmodule
bind gtm_timer gtm_timer_props u_props (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .pwm_a_o(pwm_a_o),
    .pwm_b_o(pwm_b_o), .irq_o(irq_o));

// ### test/tb_top.sv
// Self-checking bench for the timer
`timescale 1ns/10ps
module tb_top;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic wen = 1'b0;
    logic ren = 1'b0;
    logic ccp_a, ccp_b, pwm_a, pwm_b, irq;
    logic [31:0] rdata, d;
    int n, n_fail = 0, n_checks = 0;
    logic [11:0] ra[9] = '{12'h000, 12'h00C, 12'h028, 12'h02C, 12'h030, 12'h038, 12'h048, 12'h04C, 12'h0FC};
    logic [31:0] rv[9] = '{0, 0, 32'hFFFF_FFFF, 32'hFFFF, 32'hFFFF_FFFF, 0, 32'hFFFF_FFFF, 32'hFFFF, 0};
    logic [1:0] ev[3] = '{2'h0, 2'h1, 2'h3};
    int np[3] = '{3, 3, 1};
    // 10 MHz clock
    always #50 ref_clk = ~ref_clk;
    gtm_timer DUT (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .addr_i(addr), .wr_data_i(wdata), .wr_en_i(wen),
        .rd_en_i(ren), .ccp_a_i(ccp_a), .ccp_b_i(ccp_b), .freeze_i(1'b0), .rd_data_o(rdata), .pwm_a_o(pwm_a),
        .pwm_b_o(pwm_b), .irq_o(irq));
    gtm_ccp_src src (.ccp_a_o(ccp_a), .ccp_b_o(ccp_b));
    // Bus cycles, driven after a rising edge
    task wr(input logic [11:0] a, logic [31:0] v);
        addr <= a;
        wdata <= v;
        wen <= 1'b1;
        @(posedge ref_clk);
        wen <= 1'b0;
    endtask
    task rd(input logic [11:0] a, output logic [31:0] v);
        addr <= a;
        ren <= 1'b1;
        @(posedge ref_clk);
        ren <= 1'b0;
        #1 v = rdata;
        @(posedge ref_clk);
    endtask
    task chk(input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task rc(input logic [11:0] a, logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(v, exp);
    endtask
    task gap(input int c);
        repeat (c) @(posedge ref_clk);
    endtask
    // Cycles until the interrupt, bounded
    task wait_irq(output int c);
        c = 0;
        while (irq !== 1'b1 && c < 40) begin
            @(posedge ref_clk);
            #1 c++;
        end
        @(posedge ref_clk);
    endtask
    // Whole periods, so phase is free
    task cnt_pwm(input logic [7:0] exp);
        logic [7:0] c;
        c = 8'h00;
        gap(5);
        repeat (33) begin
            @(posedge ref_clk);
            #1 c = c + {7'h0, pwm_b};
        end
        @(posedge ref_clk);
        chk({24'h0, c}, {24'h0, exp});
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Run is some 2800 cycles; wide margin
    initial begin
        #5000000;
        n_fail++;
        wrap_up();
    end
    initial begin
        gap(2);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        for (int i = 0; i < 9; i++) rc(ra[i], rv[i]);
        wr(12'h04C, 32'h0);
        rc(12'h04C, 32'hFFFF);
        $display("reset values done");
        wr(12'h000, 32'h0);
        rc(12'h000, 32'h0);
        wr(12'h004, 32'h1);
        rc(12'h004, 32'h1);
        wr(12'h028, 32'h2);
        wr(12'h018, 32'h1);
        rc(12'h018, 32'h1);
        wr(12'h00C, 32'h1);
        wait_irq(n);
        chk(n >= 3 && n <= 5, 1);
        rc(12'h00C, 32'h0);
        rc(12'h048, 32'h2);
        rc(12'h020, 32'h1);
        wr(12'h024, 32'hFFFF_FFFF);
        rc(12'h01C, 32'h0);
        chk(irq, 0);
        $display("one-shot done");
        wr(12'h004, 32'h2);
        rc(12'h004, 32'h2);
        wr(12'h028, 32'd100);
        wr(12'h018, 32'h0);
        wr(12'h00C, 32'h1);
        rd(12'h048, d);
        chk(d >= 98 && d <= 100, 1);
        gap(220);
        rc(12'h00C, 32'h1);
        rc(12'h01C, 32'h1);
        chk(irq, 0);
        wr(12'h00C, 32'h0);
        wr(12'h024, 32'hFFFF_FFFF);
        $display("periodic done");
        wr(12'h000, 32'h4);
        rc(12'h000, 32'h4);
        wr(12'h004, 32'h1);
        wr(12'h038, 32'h1);
        wr(12'h028, 32'h2);
        wr(12'h018, 32'h1);
        wr(12'h00C, 32'h1);
        wait_irq(n);
        chk(n >= 6 && n <= 9, 1);
        wr(12'h024, 32'hFFFF_FFFF);
        wr(12'h038, 32'h0);
        $display("prescale done");
        wr(12'h008, 32'h3);
        wr(12'h02C, 32'hA);
        wr(12'h034, 32'h6);
        wr(12'h018, 32'h200);
        for (int e = 0; e < 3; e++) begin
            wr(12'h00C, {20'h0, ev[e], 10'h0});
            wr(12'h00C, {20'h0, ev[e], 10'h100});
            src.pulse(1, np[e], 400);
            gap(5);
            rc(12'h01C, 32'h0);
            src.pulse(1, 1, 400);
            gap(5);
            rc(12'h01C, 32'h200);
            chk(irq, 1);
            rc(12'h00C, {20'h0, ev[e], 10'h0});
            src.pulse(1, 2, 400);
            gap(5);
            rc(12'h04C, 32'hA);
            wr(12'h024, 32'hFFFF_FFFF);
        end
        $display("edge count done");
        wr(12'h004, 32'h7);
        wr(12'h028, 32'h1000);
        wr(12'h018, 32'h4);
        wr(12'h00C, 32'h1);
        src.pulse(0, 1, 400);
        gap(5);
        rd(12'h048, d);
        chk(d <= 32'h1000 && d > 0, 1);
        rc(12'h01C, 32'h4);
        rc(12'h00C, 32'h1);
        rc(12'h048, d);
        wr(12'h028, 32'h5);
        gap(20);
        src.pulse(0, 1, 400);
        gap(5);
        rd(12'h048, d);
        chk(d <= 5, 1);
        wr(12'h00C, 32'h0);
        wr(12'h024, 32'hFFFF_FFFF);
        $display("edge time done");
        wr(12'h008, 32'hA);
        wr(12'h02C, 32'd10);
        wr(12'h034, 32'h4);
        wr(12'h00C, 32'h100);
        cnt_pwm(8'd18);
        rc(12'h00C, 32'h100);
        wr(12'h00C, 32'h0);
        wr(12'h00C, 32'h4100);
        cnt_pwm(8'd15);
        chk(pwm_a, 0);
        wr(12'h00C, 32'h0);
        $display("waveform done");
        wr(12'h004, 32'h0);
        wr(12'h000, 32'h1);
        rc(12'h000, 32'h1);
        wr(12'h030, 32'h2);
        wr(12'h018, 32'h8);
        rc(12'h018, 32'h8);
        wr(12'h00C, 32'h1);
        for (int k = 1; k < 8; k++) begin
            src.pulse(0, 1, 15259);
            @(posedge ref_clk);
            rc(12'h048, k % 3);
            chk(irq, (k % 3) == 0);
        end
        $display("clock count done");
        wrap_up();
    end
endmodule
